/* common/cpu_bus_consts.svh */
// Shared constants for the processor bus end and its system support end
`ifndef CPU_BUS_CONSTS_SVH
`define CPU_BUS_CONSTS_SVH

// Multiplexed address/data bus width
`define ADDRESS_WIDTH 20
// Default data width of the word-wide variant
`define WORD_DATA_WIDTH 16
// First fetch address after reset
`define RESTART_ADDRESS 20'hFFFF0
// Oscillator cycles per system clock cycle
`define CLOCK_DIVIDE 3
// Least system clock cycles that reset stays active
`define RESET_HOLD_CYCLES 4
// Status code shown while no cycle runs
`define STATUS_PASSIVE 3'h7
// Command vector bit positions inside the bus controller
`define CMD_MEM_READ 0
`define CMD_MEM_WRITE 1
`define CMD_ADV_MEM_WRITE 2
`define CMD_IO_READ 3
`define CMD_IO_WRITE 4
`define CMD_ADV_IO_WRITE 5
`define CMD_INT_ACK 6
`define CMD_COUNT 7

`endif

/* common/cpu_bus_pkg.sv */
// Types shared by the processor bus end and the system support end
package cpu_bus_pkg;

	// Cycle kind, coded exactly as the three status bits top to low
	typedef enum logic [2:0] {
		KIND_INT_ACK = 3'h0,
		KIND_IO_READ = 3'h1,
		KIND_IO_WRITE = 3'h2,
		KIND_HALT = 3'h3,
		KIND_FETCH = 3'h4,
		KIND_MEM_READ = 3'h5,
		KIND_MEM_WRITE = 3'h6,
		KIND_PASSIVE = 3'h7
	} cycle_kind_type;

	// Bus phase of the processor end
	typedef enum logic [2:0] {
		PHASE_IDLE = 3'h0,
		PHASE_T1 = 3'h1,
		PHASE_T2 = 3'h2,
		PHASE_T3 = 3'h3,
		PHASE_WAIT = 3'h4,
		PHASE_T4 = 3'h5,
		PHASE_HOLD = 3'h6
	} bus_phase_type;

endpackage : cpu_bus_pkg

/* common/cpu_link_if.sv */
// Pins between the processor bus end and the system support end
interface cpu_link_if;
	// Clocking and reset made by the support end
	logic system_tick;
	logic system_clock;
	logic peripheral_clock;
	logic oscillator_passthrough;
	logic system_reset;
	logic ready;
	logic strap_min_max;
	// Pin 31 and pin 30 pair
	logic hold_request;
	logic hold_acknowledge;
	logic hold_acknowledge_oe_n;
	// Pins whose meaning follows the strap
	logic write_or_lock_n;
	logic select_or_status_top;
	logic direction_or_status_mid;
	logic enable_or_status_low;
	logic latch_or_queue_low;
	logic intack_or_queue_high;
	logic read_strobe_n;
	logic min_cycle_status_low;
	logic control_oe_n;
	// Multiplexed address/data bus
	logic [19:0] ad_out;
	logic ad_oe_n;
	logic [19:0] ad_external;
	logic [19:0] ad_in;

	// Wire level: processor wins while it drives, else the outside world
	assign ad_in = ad_oe_n ? ad_external : ad_out;

	modport cpu (
		input system_tick, system_reset, ready, strap_min_max, hold_request, ad_in,
		output hold_acknowledge, hold_acknowledge_oe_n, write_or_lock_n, select_or_status_top,
		output direction_or_status_mid, enable_or_status_low, latch_or_queue_low,
		output intack_or_queue_high, read_strobe_n, min_cycle_status_low, control_oe_n,
		output ad_out, ad_oe_n
	);

	modport support (
		output system_tick, system_clock, peripheral_clock, oscillator_passthrough,
		output system_reset, ready, strap_min_max, hold_request,
		input hold_acknowledge, hold_acknowledge_oe_n, write_or_lock_n, select_or_status_top,
		input direction_or_status_mid, enable_or_status_low, latch_or_queue_low,
		input intack_or_queue_high, read_strobe_n, min_cycle_status_low, control_oe_n,
		input ad_out, ad_oe_n, ad_in
	);
endinterface : cpu_link_if

/* src/system_support_end.sv */
// Clock generator, ready/reset synchroniser, bus master request and bus controller
`include "cpu_bus_consts.svh"

module system_support_end #(
	parameter int RESET_HOLD = `RESET_HOLD_CYCLES
) (
	// Clocking, oscillator rate
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_clock_enable,
	// Board inputs
	input wire logic i_reset_request_in_n,
	input wire logic i_strap_min_max,
	input wire logic i_ready_request_a,
	input wire logic i_ready_qualify_a_n,
	input wire logic i_ready_request_b,
	input wire logic i_ready_qualify_b_n,
	input wire logic i_bus_wanted,
	// Board outputs
	output logic o_bus_granted,
	output logic o_system_reset,
	output logic o_address_latch_strobe,
	output logic o_memory_read_command_n,
	output logic o_memory_write_command_n,
	output logic o_advanced_memory_write_command_n,
	output logic o_io_read_command_n,
	output logic o_io_write_command_n,
	output logic o_advanced_io_write_command_n,
	output logic o_interrupt_ack_command_n,
	// Link to the processor
	cpu_link_if.support link
);

	typedef struct packed {
		logic [1:0] divide;
		logic system_clock;
		logic peripheral_clock;
		logic [2:0] reset_count;
		logic system_reset;
		logic ready;
		logic hold_wanted;
		logic [2:0] status_prev;
		logic latch;
		logic [`CMD_COUNT-1:0] command;
	} support_state_type;

	support_state_type cur;
	support_state_type next_cur;
	logic tick;
	logic max_mode;
	logic [2:0] status;

	// Command vector for one status code
	function automatic logic [`CMD_COUNT-1:0] decode_status(input logic [2:0] code);
		logic [`CMD_COUNT-1:0] cmd;
		cmd = '0;
		case (code)
			3'h0: cmd[`CMD_INT_ACK] = 1'b1;
			3'h1: cmd[`CMD_IO_READ] = 1'b1;
			3'h2: cmd[`CMD_ADV_IO_WRITE] = 1'b1;
			3'h4: cmd[`CMD_MEM_READ] = 1'b1;
			3'h5: cmd[`CMD_MEM_READ] = 1'b1;
			3'h6: cmd[`CMD_ADV_MEM_WRITE] = 1'b1;
			default: cmd = '0;
		endcase
		return cmd;
	endfunction : decode_status

	assign tick = (cur.divide == 2'(`CLOCK_DIVIDE - 1));
	assign max_mode = ~i_strap_min_max;
	assign status = {link.select_or_status_top, link.direction_or_status_mid, link.enable_or_status_low};

	// Next state; everything except the divider and the system clock bit moves once per system clock
	always_comb begin
		next_cur = cur;
		next_cur.divide = tick ? 2'h0 : cur.divide + 2'h1;
		next_cur.system_clock = tick;
		if (tick) begin
			next_cur.peripheral_clock = ~cur.peripheral_clock;
			if (!i_reset_request_in_n) begin
				next_cur.reset_count = 3'h0;
			end else if (32'(cur.reset_count) < RESET_HOLD) begin
				next_cur.reset_count = cur.reset_count + 3'h1;
			end
			next_cur.system_reset = !i_reset_request_in_n || (32'(cur.reset_count) < RESET_HOLD);
			next_cur.ready = (i_ready_request_a & ~i_ready_qualify_a_n)
				| (i_ready_request_b & ~i_ready_qualify_b_n);
			next_cur.hold_wanted = i_bus_wanted;
			// Commands follow status a clock late, like a real decoder
			next_cur.status_prev = status;
			next_cur.latch = max_mode && (status != `STATUS_PASSIVE) && (cur.status_prev == `STATUS_PASSIVE);
			next_cur.command = max_mode ? decode_status(status) : '0;
			// Normal writes trail the advanced ones by one clock
			next_cur.command[`CMD_MEM_WRITE] = cur.command[`CMD_ADV_MEM_WRITE] && max_mode;
			next_cur.command[`CMD_IO_WRITE] = cur.command[`CMD_ADV_IO_WRITE] && max_mode;
		end
	end

	// Reset comes up active so the processor always restarts cleanly
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cur <= '{system_reset: 1'b1, status_prev: `STATUS_PASSIVE, default: '0};
		end else if (i_clock_enable) begin
			cur <= next_cur;
		end
	end

	// Link drive
	assign link.system_tick = tick;
	assign link.system_clock = cur.system_clock;
	assign link.peripheral_clock = cur.peripheral_clock;
	assign link.oscillator_passthrough = i_clock;
	assign link.system_reset = cur.system_reset;
	assign link.ready = cur.ready;
	assign link.strap_min_max = i_strap_min_max;
	assign link.hold_request = cur.hold_wanted;

	// Board outputs, commands active low
	assign o_bus_granted = link.hold_acknowledge & ~link.hold_acknowledge_oe_n;
	assign o_system_reset = cur.system_reset;
	assign o_address_latch_strobe = cur.latch;
	assign o_memory_read_command_n = ~cur.command[`CMD_MEM_READ];
	assign o_memory_write_command_n = ~cur.command[`CMD_MEM_WRITE];
	assign o_advanced_memory_write_command_n = ~cur.command[`CMD_ADV_MEM_WRITE];
	assign o_io_read_command_n = ~cur.command[`CMD_IO_READ];
	assign o_io_write_command_n = ~cur.command[`CMD_IO_WRITE];
	assign o_advanced_io_write_command_n = ~cur.command[`CMD_ADV_IO_WRITE];
	assign o_interrupt_ack_command_n = ~cur.command[`CMD_INT_ACK];

endmodule : system_support_end

/* src/cpu_bus_end.sv */
// Processor bus interface unit: bus cycles, wait states, hold and strap-selected pins
`include "cpu_bus_consts.svh"

module cpu_bus_end #(
	parameter int DATA_WIDTH = `WORD_DATA_WIDTH,
	parameter bit BYTE_WIDE = 1'b0
) (
	// Clocking
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_clock_enable,
	// Bus cycle requests from the execution side
	input wire logic i_cycle_request,
	input wire cpu_bus_pkg::cycle_kind_type i_cycle_kind,
	input wire logic [`ADDRESS_WIDTH-1:0] i_cycle_address,
	input wire logic [DATA_WIDTH-1:0] i_write_data,
	// Answers to the execution side
	output logic o_cycle_accept,
	output logic o_cycle_done,
	output logic [DATA_WIDTH-1:0] o_read_data,
	output logic o_holding,
	output logic o_bus_stalled,
	output logic o_max_mode,
	// Link to the support end
	cpu_link_if.cpu link
);

	typedef struct packed {
		cpu_bus_pkg::bus_phase_type phase;
		cpu_bus_pkg::cycle_kind_type kind;
		logic [`ADDRESS_WIDTH-1:0] address;
		logic [DATA_WIDTH-1:0] write_data;
		logic [DATA_WIDTH-1:0] read_data;
		logic hold_sampled;
		logic max_mode;
		logic restart_pending;
		logic accept;
		logic done;
	} cpu_state_type;

	cpu_state_type cur;
	cpu_state_type next_cur;
	logic step;
	logic strobe_window;
	logic cycle_is_write;
	logic cycle_is_read;
	logic [2:0] status;

	// True while a cycle owns the bus, T1 through T4
	function automatic logic in_cycle(input cpu_bus_pkg::bus_phase_type phase);
		return (phase == cpu_bus_pkg::PHASE_T1) || (phase == cpu_bus_pkg::PHASE_T2)
			|| (phase == cpu_bus_pkg::PHASE_T3) || (phase == cpu_bus_pkg::PHASE_WAIT)
			|| (phase == cpu_bus_pkg::PHASE_T4);
	endfunction : in_cycle

	// Status code shown on the pins; passive outside T1 to the last wait
	function automatic logic [2:0] status_of(input cpu_bus_pkg::bus_phase_type phase,
		input cpu_bus_pkg::cycle_kind_type kind);
		if (in_cycle(phase) && (phase != cpu_bus_pkg::PHASE_T4)) begin
			return kind;
		end
		return `STATUS_PASSIVE;
	endfunction : status_of

	// Write kinds drive data after T1
	function automatic logic writes(input cpu_bus_pkg::cycle_kind_type kind);
		return (kind == cpu_bus_pkg::KIND_IO_WRITE) || (kind == cpu_bus_pkg::KIND_MEM_WRITE);
	endfunction : writes

	// The whole unit moves on the system clock made by the support end
	assign step = i_clock_enable && link.system_tick;

	// Next state
	always_comb begin
		next_cur = cur;
		next_cur.accept = 1'b0;
		next_cur.done = 1'b0;
		next_cur.hold_sampled = link.hold_request && !cur.max_mode;
		if (link.system_reset) begin
			// Strap caught only while reset is active, so a moving pin cannot upset a cycle
			next_cur.max_mode = ~link.strap_min_max;
			next_cur.phase = cpu_bus_pkg::PHASE_IDLE;
			next_cur.restart_pending = 1'b1;
		end else begin
			case (cur.phase)
				cpu_bus_pkg::PHASE_IDLE: begin
					if (cur.hold_sampled) begin
						next_cur.phase = cpu_bus_pkg::PHASE_HOLD;
					end else if (cur.restart_pending) begin
						next_cur.phase = cpu_bus_pkg::PHASE_T1;
						next_cur.kind = cpu_bus_pkg::KIND_FETCH;
						next_cur.address = `RESTART_ADDRESS;
						next_cur.restart_pending = 1'b0;
					end else if (i_cycle_request) begin
						next_cur.phase = cpu_bus_pkg::PHASE_T1;
						next_cur.kind = i_cycle_kind;
						next_cur.address = i_cycle_address;
						next_cur.write_data = i_write_data;
						next_cur.accept = 1'b1;
					end
				end
				cpu_bus_pkg::PHASE_T1: begin
					next_cur.phase = cpu_bus_pkg::PHASE_T2;
				end
				cpu_bus_pkg::PHASE_T2: begin
					next_cur.phase = cpu_bus_pkg::PHASE_T3;
				end
				cpu_bus_pkg::PHASE_T3, cpu_bus_pkg::PHASE_WAIT: begin
					// Ready is already registered by the support end, so it is only read here
					if (link.ready) begin
						next_cur.phase = cpu_bus_pkg::PHASE_T4;
						next_cur.read_data = link.ad_in[DATA_WIDTH-1:0];
						next_cur.done = 1'b1;
					end else begin
						next_cur.phase = cpu_bus_pkg::PHASE_WAIT;
					end
				end
				cpu_bus_pkg::PHASE_T4: begin
					next_cur.phase = cur.hold_sampled ? cpu_bus_pkg::PHASE_HOLD
						: cpu_bus_pkg::PHASE_IDLE;
				end
				cpu_bus_pkg::PHASE_HOLD: begin
					if (!cur.hold_sampled) begin
						next_cur.phase = cpu_bus_pkg::PHASE_IDLE;
					end
				end
				default: begin
					next_cur.phase = cpu_bus_pkg::PHASE_IDLE;
				end
			endcase
		end
	end

	// State register; clears to idle, the support end's reset then restarts it
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cur <= '{phase: cpu_bus_pkg::PHASE_IDLE, kind: cpu_bus_pkg::KIND_PASSIVE, default: '0};
		end else if (step) begin
			cur <= next_cur;
		end
	end

	// Decoded cycle properties
	assign status = status_of(cur.phase, cur.kind);
	assign strobe_window = (cur.phase == cpu_bus_pkg::PHASE_T2) || (cur.phase == cpu_bus_pkg::PHASE_T3)
		|| (cur.phase == cpu_bus_pkg::PHASE_WAIT);
	assign cycle_is_write = writes(cur.kind);
	assign cycle_is_read = (cur.kind == cpu_bus_pkg::KIND_IO_READ) || (cur.kind == cpu_bus_pkg::KIND_FETCH)
		|| (cur.kind == cpu_bus_pkg::KIND_MEM_READ);

	// Hold pin pair: request/grant lines are not driven, so maximum mode floats pin 30
	assign link.hold_acknowledge = !cur.max_mode && (cur.phase == cpu_bus_pkg::PHASE_HOLD);
	assign link.hold_acknowledge_oe_n = cur.max_mode;

	// Pins whose meaning follows the strap
	assign link.write_or_lock_n = cur.max_mode ? 1'b1
		: ~(strobe_window && cycle_is_write);
	assign link.select_or_status_top = cur.max_mode ? status[2]
		: (BYTE_WIDE ? ~status[2] : status[2]);
	assign link.direction_or_status_mid = status[1];
	assign link.enable_or_status_low = cur.max_mode ? status[0] : ~strobe_window;
	assign link.latch_or_queue_low = !cur.max_mode && (cur.phase == cpu_bus_pkg::PHASE_T1);
	assign link.intack_or_queue_high = !cur.max_mode
		&& !(strobe_window && (cur.kind == cpu_bus_pkg::KIND_INT_ACK));
	assign link.read_strobe_n = ~(strobe_window && cycle_is_read);
	assign link.min_cycle_status_low = (BYTE_WIDE && !cur.max_mode) ? status[0] : 1'b1;

	// Controls float during hold so the bus master can drive them
	assign link.control_oe_n = (cur.phase == cpu_bus_pkg::PHASE_HOLD);

	// Address in T1, write data from T2 to T4, floated otherwise
	assign link.ad_out = (cur.phase == cpu_bus_pkg::PHASE_T1) ? cur.address
		: {{(`ADDRESS_WIDTH - DATA_WIDTH){1'b0}}, cur.write_data};
	assign link.ad_oe_n = ~((cur.phase == cpu_bus_pkg::PHASE_T1)
		|| (cycle_is_write && in_cycle(cur.phase)));

	// Execution side answers
	assign o_cycle_accept = cur.accept;
	assign o_cycle_done = cur.done;
	assign o_read_data = cur.read_data;
	assign o_holding = (cur.phase == cpu_bus_pkg::PHASE_HOLD);
	assign o_bus_stalled = i_cycle_request && (cur.phase == cpu_bus_pkg::PHASE_HOLD);
	assign o_max_mode = cur.max_mode;

endmodule : cpu_bus_end

/* dv/cpu_clock_ready_mode_status_sva.sv */
// Concurrent checks on the pins joining the processor end and the support end
module cpu_clock_ready_mode_status_sva (
	// Clocking and reset
	input wire logic oscillator_passthrough,
	input wire logic system_reset,
	input wire logic system_tick,
	input wire logic system_clock,
	input wire logic peripheral_clock,
	input wire logic ready,
	input wire logic strap_min_max,
	// Hold handshake
	input wire logic hold_request,
	input wire logic hold_acknowledge,
	input wire logic hold_acknowledge_oe_n,
	// Strap-selected pins
	input wire logic write_or_lock_n,
	input wire logic latch_or_queue_low,
	input wire logic intack_or_queue_high,
	input wire logic read_strobe_n,
	input wire logic control_oe_n,
	input wire logic ad_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD_TICKS = 4;
	logic [3:0] reset_ticks = 4'h0;

	default clocking main_edge @(posedge oscillator_passthrough);
	endclocking
	default disable iff (system_reset);

	// Ticks seen while reset is high; saturates so a long reset cannot wrap back below the minimum
	always_ff @(posedge oscillator_passthrough) begin
		if (!system_reset) begin
			reset_ticks <= 4'h0;
		end else if (system_tick && reset_ticks != 4'hF) begin
			reset_ticks <= reset_ticks + 4'h1;
		end
	end

	a_tick_every_third: assert property (system_tick |=> !system_tick ##1 !system_tick ##1 system_tick)
		else $error("system tick spacing wrong");
	a_clock_third_rate: assert property ($rose(system_clock) |=> !system_clock [*2] ##1 system_clock)
		else $error("system clock period wrong");
	a_peripheral_half_rate: assert property (system_tick |=> $changed(peripheral_clock))
		else $error("peripheral clock missed a toggle");
	a_ready_on_tick: assert property ($changed(ready) |-> $past(system_tick))
		else $error("ready changed off the system tick");
	a_reset_four_ticks: assert property ($fell(system_reset) |-> reset_ticks >= HOLD_TICKS)
		else $error("reset released too early");
	a_hold_floats_bus: assert property (strap_min_max && hold_acknowledge && !hold_acknowledge_oe_n
		|-> control_oe_n && ad_oe_n)
		else $error("bus driven while hold acknowledged");
	a_hold_kept: assert property (strap_min_max && hold_request && hold_acknowledge
		&& !hold_acknowledge_oe_n |=> hold_acknowledge)
		else $error("hold dropped while still requested");
	a_hold_released: assert property (strap_min_max && $fell(hold_request) |-> ##[1:12] !hold_acknowledge)
		else $error("hold not left after release");
	a_max_pins_fixed: assert property (!strap_min_max |-> write_or_lock_n && !latch_or_queue_low
		&& !intack_or_queue_high && hold_acknowledge_oe_n)
		else $error("maximum mode pin not in its fixed state");
	a_min_one_strobe: assert property (strap_min_max && !control_oe_n && !read_strobe_n
		|-> write_or_lock_n && intack_or_queue_high)
		else $error("two command strobes active together");

	// Main scenarios reached
	cover property (strap_min_max && hold_acknowledge && !hold_acknowledge_oe_n);
	cover property ($fell(ready));
	cover property (!strap_min_max && $fell(system_reset));
endmodule : cpu_clock_ready_mode_status_sva

/* dv/cpu_clock_ready_mode_status_bench.sv */
// Self-checking bench joining the processor end to the system support end
`include "cpu_bus_consts.svh"

module cpu_clock_ready_mode_status_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus
	logic i_clock = 1'b0;
	logic i_reset_n, i_cycle_request, i_reset_request_in_n, i_strap_min_max, i_bus_wanted;
	logic i_ready_request_a, i_ready_qualify_a_n, i_ready_request_b, i_ready_qualify_b_n;
	cpu_bus_pkg::cycle_kind_type i_cycle_kind;
	logic [19:0] i_cycle_address;
	logic [15:0] i_write_data, o_read_data;
	// Observed
	logic o_cycle_accept, o_cycle_done, o_holding, o_bus_stalled, o_max_mode;
	logic o_bus_granted, o_system_reset, o_address_latch_strobe;
	// One port drives each bit, so this is a net rather than a variable
	wire logic [6:0] cmd_n;
	int err_count = 0;
	int samples_checked = 0;
	int n;

	cpu_link_if link();

	cpu_bus_end cpu_bus_end_i (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_clock_enable(1'b1),
		.i_cycle_request(i_cycle_request),
		.i_cycle_kind(i_cycle_kind),
		.i_cycle_address(i_cycle_address),
		.i_write_data(i_write_data),
		.o_cycle_accept(o_cycle_accept),
		.o_cycle_done(o_cycle_done),
		.o_read_data(o_read_data),
		.o_holding(o_holding),
		.o_bus_stalled(o_bus_stalled),
		.o_max_mode(o_max_mode),
		.link(link)
	);

	system_support_end system_support_end_i (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_clock_enable(1'b1),
		.i_reset_request_in_n(i_reset_request_in_n),
		.i_strap_min_max(i_strap_min_max),
		.i_ready_request_a(i_ready_request_a),
		.i_ready_qualify_a_n(i_ready_qualify_a_n),
		.i_ready_request_b(i_ready_request_b),
		.i_ready_qualify_b_n(i_ready_qualify_b_n),
		.i_bus_wanted(i_bus_wanted),
		.o_bus_granted(o_bus_granted),
		.o_system_reset(o_system_reset),
		.o_address_latch_strobe(o_address_latch_strobe),
		.o_memory_read_command_n(cmd_n[`CMD_MEM_READ]),
		.o_memory_write_command_n(cmd_n[`CMD_MEM_WRITE]),
		.o_advanced_memory_write_command_n(cmd_n[`CMD_ADV_MEM_WRITE]),
		.o_io_read_command_n(cmd_n[`CMD_IO_READ]),
		.o_io_write_command_n(cmd_n[`CMD_IO_WRITE]),
		.o_advanced_io_write_command_n(cmd_n[`CMD_ADV_IO_WRITE]),
		.o_interrupt_ack_command_n(cmd_n[`CMD_INT_ACK]),
		.link(link)
	);

	cpu_clock_ready_mode_status_sva cpu_clock_ready_mode_status_sva_i (
		.oscillator_passthrough(link.oscillator_passthrough),
		.system_reset(link.system_reset),
		.system_tick(link.system_tick),
		.system_clock(link.system_clock),
		.peripheral_clock(link.peripheral_clock),
		.ready(link.ready),
		.strap_min_max(link.strap_min_max),
		.hold_request(link.hold_request),
		.hold_acknowledge(link.hold_acknowledge),
		.hold_acknowledge_oe_n(link.hold_acknowledge_oe_n),
		.write_or_lock_n(link.write_or_lock_n),
		.latch_or_queue_low(link.latch_or_queue_low),
		.intack_or_queue_high(link.intack_or_queue_high),
		.read_strobe_n(link.read_strobe_n),
		.control_oe_n(link.control_oe_n),
		.ad_oe_n(link.ad_oe_n)
	);

	// Oscillator-rate clock
	always #5 i_clock = ~i_clock;

	// Sample at system tick edges, before that edge's updates land
	task automatic tick(input int count);
		repeat (count) @(posedge i_clock iff link.system_tick === 1'b1);
	endtask : tick

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [2:0] status();
		return {link.select_or_status_top, link.direction_or_status_mid, link.enable_or_status_low};
	endfunction : status

	// Reset by the async pin or by the reset request; strap changes only while reset is high
	task automatic restart(input logic strap, input bit hard);
		if (hard) begin
			repeat (20) @(posedge i_clock);
			i_reset_n <= 1'b1;
		end else begin
			i_reset_request_in_n <= 1'b0;
			tick(3);
			check(o_system_reset, 1'b1);
			i_strap_min_max <= strap;
			tick(1);
			i_reset_request_in_n <= 1'b1;
		end
		n = 0;
		do begin tick(1); n++; end while (link.system_reset !== 1'b0 && n < 40);
		check(n >= 4, 1'b1);
		n = 0;
		do begin tick(1); n++; end while ((strap ? link.latch_or_queue_low : status() === 3'h4) !== 1'b1 && n < 20);
		check(n, 1);
		check(link.ad_out, `RESTART_ADDRESS);
		check(o_max_mode, !strap);
	endtask : restart

	// One bus cycle; lower picks ready lines {b,a} pulled low, raised again at tick raise_at after T1
	task automatic run_cycle(input cpu_bus_pkg::cycle_kind_type kind, input logic [19:0] addr,
			input logic [1:0] lower, input int raise_at, input int waits);
		int j;
		logic [6:0] cmd;
		cmd = 7'h00;
		cmd[`CMD_MEM_READ] = kind inside {cpu_bus_pkg::KIND_FETCH, cpu_bus_pkg::KIND_MEM_READ};
		cmd[`CMD_MEM_WRITE] = kind == cpu_bus_pkg::KIND_MEM_WRITE;
		cmd[`CMD_ADV_MEM_WRITE] = cmd[`CMD_MEM_WRITE];
		cmd[`CMD_IO_READ] = kind == cpu_bus_pkg::KIND_IO_READ;
		cmd[`CMD_IO_WRITE] = kind == cpu_bus_pkg::KIND_IO_WRITE;
		cmd[`CMD_ADV_IO_WRITE] = cmd[`CMD_IO_WRITE];
		cmd[`CMD_INT_ACK] = kind == cpu_bus_pkg::KIND_INT_ACK;
		i_cycle_request <= 1'b1;
		i_cycle_kind <= kind;
		i_cycle_address <= addr;
		i_write_data <= addr[15:0];
		if (lower[0]) i_ready_request_a <= 1'b0;
		if (lower[1]) i_ready_request_b <= 1'b0;
		j = 0;
		do begin tick(1); j++; end while (o_cycle_accept !== 1'b1 && j < 80);
		i_cycle_request <= 1'b0;
		check(link.ad_out, addr);
		if (i_strap_min_max) check(link.latch_or_queue_low, 1'b1);
		j = 0;
		while (o_cycle_done !== 1'b1 && j < 40) begin
			if (j == raise_at) begin
				i_ready_request_a <= 1'b1;
				i_ready_request_b <= 1'b1;
			end
			tick(1);
			j++;
			if (j == 1 && !i_strap_min_max) check(o_address_latch_strobe, 1'b1);
			if (j == 2 && !i_strap_min_max) check({status(), ~cmd_n}, {kind, cmd});
			// Word-wide part: select high means memory, low status pin parked high
			if (j == 2 && i_strap_min_max) check({link.read_strobe_n, link.write_or_lock_n,
				link.intack_or_queue_high, link.select_or_status_top, link.direction_or_status_mid,
				link.min_cycle_status_low}, {!(cmd[0] || cmd[3]), !(cmd[1] || cmd[4]), !cmd[6], kind[2], kind[1],
				1'b1});
		end
		check(j, 3 + waits);
		if (kind inside {cpu_bus_pkg::KIND_FETCH, cpu_bus_pkg::KIND_MEM_READ, cpu_bus_pkg::KIND_IO_READ}) begin
			check(o_read_data, 16'hC5A9);
		end
		if (!i_strap_min_max) check(status(), 3'h7);
	endtask : run_cycle

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		i_reset_n = 1'b0;
		i_cycle_request = 1'b0;
		i_cycle_kind = cpu_bus_pkg::KIND_PASSIVE;
		i_cycle_address = 20'h00000;
		i_write_data = 16'h0000;
		i_reset_request_in_n = 1'b1;
		i_strap_min_max = 1'b1;
		i_bus_wanted = 1'b0;
		i_ready_request_a = 1'b1;
		i_ready_qualify_a_n = 1'b0;
		i_ready_request_b = 1'b1;
		i_ready_qualify_b_n = 1'b1;
		link.ad_external = 20'h3C5A9;
		restart(1'b1, 1'b1);
		$display("test reset done");
		for (int k = 0; k < 7; k++) begin
			run_cycle(cpu_bus_pkg::cycle_kind_type'(k), 20'hA0000 | 20'(k), 2'b00, 0, 0);
		end
		$display("test minimum mode cycles done");
		run_cycle(cpu_bus_pkg::KIND_MEM_READ, 20'h12345, 2'b01, 2, 2);
		// Swap which ready input is qualified: the unqualified one must be ignored
		i_ready_qualify_a_n <= 1'b1;
		i_ready_qualify_b_n <= 1'b0;
		run_cycle(cpu_bus_pkg::KIND_IO_READ, 20'h00456, 2'b01, 2, 0);
		run_cycle(cpu_bus_pkg::KIND_MEM_WRITE, 20'h789AB, 2'b10, 1, 1);
		i_ready_qualify_a_n <= 1'b0;
		i_ready_qualify_b_n <= 1'b1;
		$display("test wait states done");
		// Hold from idle; a cycle asked for meanwhile stalls until release
		i_bus_wanted <= 1'b1;
		n = 0;
		do begin tick(1); n++; end while (o_bus_granted !== 1'b1 && n < 20);
		check({link.hold_acknowledge, link.control_oe_n, link.ad_oe_n, o_holding}, 4'hF);
		i_cycle_request <= 1'b1;
		i_cycle_kind <= cpu_bus_pkg::KIND_MEM_WRITE;
		tick(4);
		check({o_bus_stalled, o_cycle_accept, o_holding}, 3'h5);
		i_bus_wanted <= 1'b0;
		run_cycle(cpu_bus_pkg::KIND_MEM_WRITE, 20'h0BEEF, 2'b00, 0, 0);
		$display("test hold done");
		restart(1'b0, 1'b0);
		for (int k = 0; k < 7; k++) begin
			run_cycle(cpu_bus_pkg::cycle_kind_type'(k), 20'h50000 | 20'(k), 2'b00, 0, 0);
		end
		run_cycle(cpu_bus_pkg::KIND_IO_WRITE, 20'h00321, 2'b01, 1, 1);
		$display("test maximum mode done");
		give_verdict();
	end

	// Whole run is a few hundred oscillator cycles; this limit only catches a hang
	initial begin
		#600000;
		err_count++;
		$display("watchdog expired at %0t", $time);
		give_verdict();
	end
endmodule : cpu_clock_ready_mode_status_bench
